// >>> fsps_sequencer.v
// flash self-programming sequencer with apb register access
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "fsps_defs.vh"
module fsps_sequencer #(
  parameter PROG_CYCLES = `FSPS_PROG_CYCLES,
  parameter WORDS = 32,
  parameter [7:0] FUSE_LOW = 8'hE1,
  parameter [7:0] FUSE_HIGH = 8'hD9
) (
  input wire CLOCK,
  input wire RESET_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire EEPROM_WRITE_BUSY,
  output reg READY_IRQ,
  output reg CPU_HALT,
  output reg RWW_BLOCKED,
  output reg [15:0] FLASH_ADDR,
  output reg [15:0] FLASH_DATA,
  output reg FLASH_WORD_STROBE,
  output reg FLASH_ERASE,
  output reg FLASH_WRITE
);
  localparam ST_IDLE = 2'h0;
  localparam ST_PROG = 2'h1;
  localparam ST_LOCK = 2'h2;

  // software-visible state
  reg [7:0] ctrl_reg;
  reg [15:0] ptr_reg;
  reg [15:0] data_reg;
  reg [2:0] win_reg;

  // operation sequencing
  reg [1:0] state_reg;
  reg [31:0] timer_reg;
  reg [6:0] page_reg;
  reg op_erase_reg;
  reg [7:0] lock_reg;
  reg [7:0] lock_pend_reg;

  // temporary page buffer
  reg [15:0] buf_mem [0:WORDS-1];
  wire [WORDS-1:0] buf_valid;
  reg [7:0] load_byte;

  // bus phase decode
  wire setup;
  wire wr;
  wire rd;
  wire load;
  wire ctrl_wr;

  // command decode
  wire [4:0] cmd;
  wire [6:0] zpage;
  wire [4:0] zword;
  wire armed;
  wire store;
  wire store_load;
  wire store_prog;
  wire store_lock;
  wire store_reen;
  wire cmd_accept;
  wire win_tick;
  wire lock_read_ok;
  wire lock_read;
  wire op_done;
  wire buf_discard;
  wire buf_clear;
  genvar g;

  // the five accepted low-bit patterns; all others leave the command bits alone
  function valid_cmd;
    input [4:0] c;
    begin
      valid_cmd = (c == `FSPS_CMD_REEN) | (c == `FSPS_CMD_LOCK) | (c == `FSPS_CMD_WRITE) |
        (c == `FSPS_CMD_ERASE) | (c == `FSPS_CMD_LOAD); // RL24
    end
  endfunction

  // pages up to the last read-while-write page may be programmed while code runs
  function page_in_rww;
    input [6:0] p;
    begin
      page_in_rww = (p <= `FSPS_RWW_LAST_PAGE);
    end
  endfunction

  // which offsets exist for a read and for a write
  function addr_mapped;
    input [7:0] a;
    input w;
    begin
      case (a)
        `FSPS_ADDR_CTRL: addr_mapped = 1'b1;
        `FSPS_ADDR_PTR: addr_mapped = 1'b1;
        `FSPS_ADDR_DATA: addr_mapped = 1'b1;
        `FSPS_ADDR_CMD: addr_mapped = w;
        `FSPS_ADDR_LOAD: addr_mapped = ~w;
        `FSPS_ADDR_EXT: addr_mapped = ~w;
        default: addr_mapped = 1'b0;
      endcase
    end
  endfunction

  assign setup = PSEL & ~PENABLE;
  assign wr = setup & PWRITE;
  assign rd = setup & ~PWRITE;
  assign load = rd & (PADDR == `FSPS_ADDR_LOAD);
  assign ctrl_wr = wr & (PADDR == `FSPS_ADDR_CTRL);

  assign cmd = ctrl_reg[4:0];
  assign zpage = ptr_reg[12:6]; // RL26
  assign zword = ptr_reg[5:1]; // RL26

  // the enable window only runs while no operation is in flight
  assign win_tick = (win_reg != 3'h0) & (state_reg == ST_IDLE);
  assign armed = ctrl_reg[`FSPS_BIT_EN] & win_tick; // RL23
  assign store = wr & (PADDR == `FSPS_ADDR_CMD) & armed & ~EEPROM_WRITE_BUSY; // RL16
  assign store_load = store & (cmd == `FSPS_CMD_LOAD); // RL3
  assign store_prog = store & ((cmd == `FSPS_CMD_ERASE) | (cmd == `FSPS_CMD_WRITE)); // RL1 RL7
  assign store_lock = store & (cmd == `FSPS_CMD_LOCK); // RL10
  assign store_reen = store & (cmd == `FSPS_CMD_REEN);
  // eeprom writes and busy flash refuse new commands
  assign cmd_accept = valid_cmd(PWDATA[4:0]) & (state_reg == ST_IDLE) & ~EEPROM_WRITE_BUSY; // RL16

  // lock read is valid only during the three-cycle window
  assign lock_read_ok = armed & (cmd == `FSPS_CMD_LOCK) &
    (win_reg > (`FSPS_STORE_WIN - `FSPS_LOAD_WIN)) & ~EEPROM_WRITE_BUSY; // RL16 RL17
  assign lock_read = load & lock_read_ok; // RL18
  assign op_done = (state_reg != ST_IDLE) & (timer_reg <= 32'h1);
  // an eeprom write mid-load loses whatever was loaded
  assign buf_discard = EEPROM_WRITE_BUSY & (|buf_valid); // RL6
  assign buf_clear = store_reen | buf_discard |
    (op_done & (state_reg == ST_PROG) & ~op_erase_reg); // RL4

  // program-load path: armed lock or fuse read, otherwise a buffer byte
  always @*
  begin
    load_byte = 8'hFF;
    if (lock_read_ok)
    begin
      case (ptr_reg)
        `FSPS_PTR_LOCK: load_byte = lock_reg; // RL17 RL21
        `FSPS_PTR_FLOW: load_byte = FUSE_LOW; // RL19
        `FSPS_PTR_FHIGH: load_byte = FUSE_HIGH; // RL20
        default: load_byte = 8'hFF;
      endcase
    end
    else if (!buf_valid[zword])
      load_byte = 8'hFF;
    else if (ptr_reg[0])
      load_byte = buf_mem[zword][15:8]; // RL22
    else
      load_byte = buf_mem[zword][7:0]; // RL22
  end

  // buffer words carry no reset; the valid flags say what is loaded
  always @(posedge CLOCK)
  begin
    if (store_load)
      buf_mem[zword] <= data_reg; // RL3
  end

  generate
    for (g = 0; g < WORDS; g = g + 1)
    begin : g_word
      reg valid_reg;
      always @(posedge CLOCK or negedge RESET_N)
      begin
        if (!RESET_N)
          valid_reg <= 1'b0; // RL4
        else if (store_load && (zword == g))
          valid_reg <= 1'b1;
        else if (buf_clear)
          valid_reg <= 1'b0; // RL4 RL6
      end
      assign buf_valid[g] = valid_reg;
    end
  endgenerate

  // pointer and data pair
  always @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ptr_reg <= 16'h0000;
      data_reg <= 16'h0000;
    end
    else
    begin
      if (wr & (PADDR == `FSPS_ADDR_PTR))
        ptr_reg <= PWDATA[15:0];
      if (wr & (PADDR == `FSPS_ADDR_DATA))
        data_reg <= PWDATA[15:0];
    end
  end

  // control register: command bits, busy flag and the enable window
  always @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ctrl_reg <= 8'h00;
      win_reg <= 3'h0;
    end
    else
    begin
      if (win_tick)
      begin
        win_reg <= win_reg - 3'h1;
        if (win_reg == 3'h1)
          ctrl_reg[4:0] <= 5'h00; // RL18 RL23
      end
      if (lock_read)
      begin
        ctrl_reg[4:0] <= 5'h00; // RL18
        win_reg <= 3'h0;
      end
      if (ctrl_wr)
      begin
        ctrl_reg[`FSPS_BIT_IE] <= PWDATA[7];
        if (cmd_accept) // RL24
        begin
          ctrl_reg[4:0] <= PWDATA[4:0];
          win_reg <= `FSPS_STORE_WIN; // RL23
        end
      end
      if (store)
        win_reg <= 3'h0;
      // erase, write and lock stored before the window's last cycle keep the enable bit up until they finish
      if (store_load | store_reen)
      begin
        ctrl_reg[4:0] <= 5'h00;
        ctrl_reg[`FSPS_BIT_BUSY] <= 1'b0;
      end
      if (store_prog & page_in_rww(zpage))
        ctrl_reg[`FSPS_BIT_BUSY] <= 1'b1; // RL14
      if (op_done)
        ctrl_reg[4:0] <= 5'h00; // RL23
    end
  end

  // operation timer; the target page is latched at the start
  always @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_reg <= ST_IDLE;
      timer_reg <= 32'h00000000;
      page_reg <= 7'h00;
      op_erase_reg <= 1'b0;
      lock_reg <= `FSPS_LOCK_RESET;
      lock_pend_reg <= 8'hFF;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (store_prog)
          begin
            page_reg <= zpage; // RL8
            op_erase_reg <= (cmd == `FSPS_CMD_ERASE);
            timer_reg <= PROG_CYCLES; // RL25
            state_reg <= ST_PROG;
          end
          else if (store_lock)
          begin
            lock_pend_reg <= lock_reg & {2'h3, data_reg[5:2], 2'h3}; // RL10 RL11
            timer_reg <= PROG_CYCLES; // RL25
            state_reg <= ST_LOCK; // RL12
          end
        end
        ST_PROG, ST_LOCK:
        begin
          if (timer_reg > 32'h1)
            timer_reg <= timer_reg - 32'h1;
          else
          begin
            state_reg <= ST_IDLE;
            if (state_reg == ST_LOCK)
              lock_reg <= lock_pend_reg;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // zero-wait slave: ready in the access phase after every setup
  always @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= setup;
      PSLVERR <= setup & ~addr_mapped(PADDR, PWRITE);
      if (rd)
      begin
        case (PADDR)
          `FSPS_ADDR_CTRL: PRDATA <= {24'h000000, ctrl_reg[7:6], 1'b0, ctrl_reg[4:0]};
          `FSPS_ADDR_PTR: PRDATA <= {16'h0000, ptr_reg};
          `FSPS_ADDR_DATA: PRDATA <= {16'h0000, data_reg};
          `FSPS_ADDR_LOAD: PRDATA <= {24'h000000, load_byte};
          `FSPS_ADDR_EXT: PRDATA <= {30'h00000000, CPU_HALT, RWW_BLOCKED};
          default: PRDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // flash-side pulses and section status
  always @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      READY_IRQ <= 1'b0;
      CPU_HALT <= 1'b0;
      RWW_BLOCKED <= 1'b0;
      FLASH_ADDR <= 16'h0000;
      FLASH_DATA <= 16'h0000;
      FLASH_WORD_STROBE <= 1'b0;
      FLASH_ERASE <= 1'b0;
      FLASH_WRITE <= 1'b0;
    end
    else
    begin
      FLASH_WORD_STROBE <= 1'b0;
      FLASH_ERASE <= 1'b0;
      FLASH_WRITE <= 1'b0;
      READY_IRQ <= ctrl_reg[`FSPS_BIT_IE] & ~ctrl_reg[`FSPS_BIT_EN]; // RL13
      if (store_load)
      begin
        FLASH_ADDR <= {11'h000, zword};
        FLASH_DATA <= data_reg;
        FLASH_WORD_STROBE <= 1'b1;
        RWW_BLOCKED <= 1'b0;
      end
      if (store_prog)
      begin
        FLASH_ADDR <= {3'h0, zpage, 6'h00};
        FLASH_ERASE <= (cmd == `FSPS_CMD_ERASE); // RL1
        FLASH_WRITE <= (cmd == `FSPS_CMD_WRITE); // RL7
        if (page_in_rww(zpage))
          RWW_BLOCKED <= 1'b1; // RL2 RL14
        else
          CPU_HALT <= 1'b1; // RL2
      end
      else if (state_reg == ST_PROG)
        FLASH_ADDR <= {3'h0, page_reg, 6'h00}; // RL8
      if (store_reen)
        RWW_BLOCKED <= 1'b0;
      if (op_done)
        CPU_HALT <= 1'b0;
    end
  end
endmodule // fsps_sequencer
`default_nettype wire

// >>> fsps_defs.vh
// constants for the flash self-programming sequencer
// Functional notes
// (RL1) erase: 00011 then store within four
// (RL2) rww op keeps other section; no_read_while_write_section halts cpu
// (RL3) load: 00001 then store writes buffer word
// (RL4) buffer cleared on write, reenable, reset
// (RL5) software loads each buffer word once
// (RL6) eeprom write mid-load discards buffer
// (RL7) write: 00101 then store programs page
// (RL8) target page latched at operation start
// (RL9) software uses same page for erase/write
// (RL10) lock set: 01001 then store, data low
// (RL11) zero in data bits 5..2 programs lock
// (RL12) lock programming blocks no section
// (RL13) ready interrupt while enable bit clear
// (RL14) erase/write blocks rww, busy flag set
// (RL15) software reenables section after programming
// (RL16) eeprom write refuses programming and reads
// (RL17) pointer 1 lock read returns lock byte
// (RL18) lock-set/enable clear after read or timeout
// (RL19) pointer 0 read returns fuse low byte
// (RL20) pointer 3 read returns fuse high byte
// (RL21) programmed reads zero, unprogrammed one
// (RL22) pointer bit 0 selects byte on load
// (RL23) enable window four cycles, held during op
// (RL24) only five command patterns accepted
// (RL25) flash operations last 3.7 to 4.5 ms
// (RL26) page bits 12:6, word bits 5:1
`ifndef FSPS_DEFS_VH
`define FSPS_DEFS_VH
`define FSPS_ADDR_CTRL 8'h00
`define FSPS_ADDR_PTR 8'h04
`define FSPS_ADDR_DATA 8'h08
`define FSPS_ADDR_CMD 8'h0C
`define FSPS_ADDR_LOAD 8'h10
`define FSPS_ADDR_EXT 8'h14
`define FSPS_CMD_ERASE 5'h03
`define FSPS_CMD_LOAD 5'h01
`define FSPS_CMD_WRITE 5'h05
`define FSPS_CMD_LOCK 5'h09
`define FSPS_CMD_REEN 5'h11
`define FSPS_BIT_EN 0
`define FSPS_BIT_LOCK 3
`define FSPS_BIT_IE 7
`define FSPS_BIT_BUSY 6
`define FSPS_STORE_WIN 3'h4
`define FSPS_LOAD_WIN 3'h3
`define FSPS_PROG_TIME_US 3700
`define FSPS_PROG_CYCLES ((`FSPS_PROG_TIME_US * 25) )
`define FSPS_PTR_LOCK 16'h0001
`define FSPS_PTR_FLOW 16'h0000
`define FSPS_PTR_FHIGH 16'h0003
`define FSPS_RWW_LAST_PAGE 7'h5F
`define FSPS_LOCK_RESET 8'hFF
`endif

// >>> fsps_props.sv
// assertion checker for the flash self-programming sequencer
`timescale 1ns/10ps
`default_nettype none
`include "fsps_defs.vh"
module fsps_props (
  input wire CLOCK,
  input wire RESET_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PREADY,
  input wire PSLVERR,
  input wire EEPROM_WRITE_BUSY,
  input wire CPU_HALT,
  input wire RWW_BLOCKED,
  input wire [15:0] FLASH_ADDR,
  input wire FLASH_WORD_STROBE,
  input wire FLASH_ERASE,
  input wire FLASH_WRITE
);
  wire any_op = FLASH_ERASE | FLASH_WRITE | FLASH_WORD_STROBE;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  sequence op_go;
    FLASH_ERASE || FLASH_WRITE;
  endsequence
  sequence rww_go;
    op_go ##0 FLASH_ADDR[12:6] <= `FSPS_RWW_LAST_PAGE;
  endsequence
  sequence no_read_while_write_section_go;
    op_go ##0 FLASH_ADDR[12:6] > `FSPS_RWW_LAST_PAGE;
  endsequence
  sequence ee_held;
    EEPROM_WRITE_BUSY && $past(EEPROM_WRITE_BUSY);
  endsequence
  apb_answer_a: assert property (PSEL && !PENABLE |=> PREADY) else $error("no answer");
  ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready too long");
  err_ready_a: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  load_pulse_a: assert property (FLASH_WORD_STROBE |=> !FLASH_WORD_STROBE) else $error("strobe");
  rww_block_a: assert property (rww_go |-> ##[0:2] RWW_BLOCKED) else $error("rww open");
  no_read_while_write_section_halt_a: assert property (no_read_while_write_section_go |-> ##[0:2] CPU_HALT) else $error("no halt");
  halt_hold_a: assert property ($rose(CPU_HALT) |-> CPU_HALT[*8]) else $error("halt short");
  ee_refuse_a: assert property (ee_held |-> !any_op) else $error("op in eeprom write");
endmodule // fsps_props
bind fsps_sequencer fsps_props u_props (.CLOCK(CLOCK), .RESET_N(RESET_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .EEPROM_WRITE_BUSY(EEPROM_WRITE_BUSY),
  .CPU_HALT(CPU_HALT), .RWW_BLOCKED(RWW_BLOCKED), .FLASH_ADDR(FLASH_ADDR),
  .FLASH_WORD_STROBE(FLASH_WORD_STROBE), .FLASH_ERASE(FLASH_ERASE), .FLASH_WRITE(FLASH_WRITE));
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the flash self-programming sequencer
`timescale 1ns/10ps
`default_nettype none
`include "fsps_defs.vh"
module testbench;
  logic CLOCK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, EEPROM_WRITE_BUSY = 0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, serr, READY_IRQ, CPU_HALT, RWW_BLOCKED;
  logic FLASH_WORD_STROBE, FLASH_ERASE, FLASH_WRITE;
  logic [15:0] FLASH_ADDR, FLASH_DATA;
  int num_errors = 0, cmp_count = 0;
  // fuse values are arbitrary
  localparam logic [7:0] FL = 8'h5A, FH = 8'hC6;
  always #20 CLOCK = ~CLOCK;
  fsps_sequencer #(.PROG_CYCLES(20), .FUSE_LOW(FL), .FUSE_HIGH(FH)) dut (.CLOCK(CLOCK),
    .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .EEPROM_WRITE_BUSY(EEPROM_WRITE_BUSY), .READY_IRQ(READY_IRQ), .CPU_HALT(CPU_HALT),
    .RWW_BLOCKED(RWW_BLOCKED), .FLASH_ADDR(FLASH_ADDR), .FLASH_DATA(FLASH_DATA),
    .FLASH_WORD_STROBE(FLASH_WORD_STROBE), .FLASH_ERASE(FLASH_ERASE), .FLASH_WRITE(FLASH_WRITE));
  task finish_test;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // entered just after a rising edge; holds everything until ready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do begin @(posedge CLOCK); n++; end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      num_errors++;
      finish_test;
    end
    rd = PRDATA;
    serr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask
  task cmd(input logic [7:0] c);
    apb(1, `FSPS_ADDR_CTRL, {24'h0, c});
    apb(1, `FSPS_ADDR_CMD, 32'h0);
  endtask
  task wait_done;
    int i;
    for (i = 0; i < 100; i++)
    begin
      apb(0, `FSPS_ADDR_CTRL, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (i == 100)
    begin
      num_errors++;
      finish_test;
    end
  endtask
  task fuse_read(input logic [15:0] p, input logic [7:0] e);
    apb(1, `FSPS_ADDR_PTR, {16'h0, p});
    apb(1, `FSPS_ADDR_CTRL, 32'h09);
    apb(0, `FSPS_ADDR_LOAD, 32'h0);
    chk("read byte", rd[7:0], e);
    apb(0, `FSPS_ADDR_CTRL, 32'h0);
    chk("arm bits", {rd[3], rd[0]}, 2'b00);
  endtask
  task t_reads;
    fuse_read(`FSPS_PTR_LOCK, `FSPS_LOCK_RESET);
    fuse_read(`FSPS_PTR_FLOW, FL);
    fuse_read(`FSPS_PTR_FHIGH, FH);
    apb(0, 8'h40, 32'h0);
    chk("unmapped", serr, 1'b1);
    apb(1, `FSPS_ADDR_CTRL, 32'h01);
    repeat (6) @(posedge CLOCK);
    apb(0, `FSPS_ADDR_CTRL, 32'h0);
    chk("window", rd[0], 1'b0);
    $display("t_reads done");
  endtask
  task t_lock;
    apb(1, `FSPS_ADDR_DATA, 32'h00EB);
    cmd(8'h09);
    chk("lock rww", {RWW_BLOCKED, CPU_HALT}, 2'b00);
    wait_done;
    fuse_read(`FSPS_PTR_LOCK, 8'hEB);
    $display("t_lock done");
  endtask
  task t_page;
    apb(1, `FSPS_ADDR_PTR, 32'h0146);
    apb(1, `FSPS_ADDR_DATA, 32'hA5C3);
    cmd(8'h01);
    chk("load data", FLASH_DATA, 16'hA5C3);
    apb(0, `FSPS_ADDR_LOAD, 32'h0);
    chk("buf low", rd[7:0], 8'hC3);
    apb(1, `FSPS_ADDR_PTR, 32'h0140);
    cmd(8'h83);
    apb(1, `FSPS_ADDR_PTR, 32'h0);
    chk("rww busy", {RWW_BLOCKED, CPU_HALT, READY_IRQ}, 3'b100);
    chk("page", FLASH_ADDR[12:6], 7'h05);
    wait_done;
    chk("irq", {RWW_BLOCKED, READY_IRQ}, 2'b11);
    cmd(8'h11);
    chk("reenable", RWW_BLOCKED, 1'b0);
    apb(1, `FSPS_ADDR_PTR, 32'h0146);
    apb(0, `FSPS_ADDR_LOAD, 32'h0);
    chk("buf clear", rd[7:0], 8'hFF);
    apb(1, `FSPS_ADDR_PTR, 32'h1800);
    cmd(8'h03);
    wait_done;
    cmd(8'h05);
    chk("no_read_while_write_section", {CPU_HALT, FLASH_ADDR[12:6]}, 8'hE0);
    wait_done;
    chk("halt end", CPU_HALT, 1'b0);
    $display("t_page done");
  endtask
  task t_refuse;
    apb(1, `FSPS_ADDR_CTRL, 32'h07);
    apb(0, `FSPS_ADDR_CTRL, 32'h0);
    chk("bad cmd", rd[4:0], 5'h00);
    apb(1, `FSPS_ADDR_PTR, 32'h0002);
    apb(1, `FSPS_ADDR_DATA, 32'h1234);
    cmd(8'h01);
    EEPROM_WRITE_BUSY <= 1'b1;
    cmd(8'h03);
    chk("ee block", RWW_BLOCKED, 1'b0);
    EEPROM_WRITE_BUSY <= 1'b0;
    apb(0, `FSPS_ADDR_LOAD, 32'h0);
    chk("ee discard", rd[7:0], 8'hFF);
    $display("t_refuse done");
  endtask
  initial
  begin
    repeat (16) @(posedge CLOCK);
    RESET_N <= 1'b1;
    @(posedge CLOCK);
    t_reads;
    t_lock;
    t_page;
    t_refuse;
    finish_test;
  end
endmodule // testbench
`default_nettype wire
